// >>> btbc_exec.sv
// btbc_exec: executes bit-test branches, decrement branches and cpu control ops.
// assumes the sequencer hands over one decoded op with its operand byte already read.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - branch_if_bit_set jumps by the signed offset past the op when the bit is 1, sfr form 4 bytes, others 3.
// - branch_if_bit_clear jumps when the bit is 0, saddr sfr and psw forms 4 bytes, acc and hl forms 3.
// - test_clear_and_branch jumps and clears the bit when it is 1, and does nothing when it is 0.
// - test_clear_and_branch on the program_status_word may change zero, aux carry and carry_flag only.
// - decrement_branch_nonzero on B or C decrements then jumps if nonzero, 2 bytes and 6 clocks.
// - decrement_branch_nonzero on a short direct byte writes it back then jumps if nonzero, 3 bytes, 8 or 10 clocks.
// - unmask_interrupts_op sets the interrupt_master_flag, 2 bytes and 6 clocks.
// - mask_all_interrupts_op clears the interrupt_master_flag, 2 bytes and 6 clocks.
// - the short count applies for high-speed ram or no data access, the long count otherwise.
// - counts run in cpu clock periods picked by the processor_clock_select_register.
// - counts hold for internal rom fetch, other fetch sources add a wait.
// - word_move_op from AX accepts only BC, DE or HL as destination.
module btbc_exec
   import btbc_pkg::*;
#(
   parameter btbc_cyc_t EXT_FETCH_WAIT = 8'h00,
   parameter btbc_cyc_t CYC_WORD_MOVE  = 8'h04
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        req_valid,
   input  wire btbc_req_s   req,
   input  wire logic        standby_release,
   output logic             busy,
   output logic             done,
   output btbc_res_s        result,
   output logic             ime,
   output logic             halted,
   output logic             stopped,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_we,
   input  wire logic        reg_re,
   output logic [31:0]      reg_rdata
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_HALT,
      ST_STOP
   } btbc_state_e;

   btbc_state_e state_r;
   logic [2:0]  clk_sel_r;
   logic [15:0] pre_r;
   logic [15:0] div_mask;
   logic        cpu_tick;
   btbc_cyc_t   cnt_r;
   btbc_cyc_t   last_cyc_r;
   btbc_res_s   pend_r;
   btbc_op_e    pend_op_r;
   logic        illegal_r;
   btbc_res_s   res_nxt;
   btbc_cyc_t   cyc_nxt;
   logic        finish;

   function automatic logic [7:0] op_len(input btbc_req_s r);
      logic [7:0] l;
      l = LEN_2;
      case (r.op)
         OP_BIT_SET: begin
            l = (r.form == FM_SFR) ? LEN_4 : LEN_3;
         end
         OP_BIT_CLR, OP_TEST_CLR: begin
            l = (r.form == FM_SADDR || r.form == FM_SFR || r.form == FM_PSW) ? LEN_4 : LEN_3;
         end
         OP_DEC_BR: begin
            l = (r.form == FM_SADDR) ? LEN_3 : LEN_2;
         end
         OP_WORD_MOVE: begin
            l = LEN_1;
         end
         default: begin
            l = LEN_2;
         end
      endcase
      return l;
   endfunction

   function automatic btbc_cyc_t pick(input logic hs, input btbc_cyc_t s, input btbc_cyc_t g);
      return hs ? s : g;
   endfunction

   function automatic btbc_cyc_t op_cycles(input btbc_req_s r);
      btbc_cyc_t c;
      c = CYC_6;
      case (r.op)
         OP_BIT_SET: begin
            case (r.form)
               FM_SADDR: c = pick(r.hs_ram, CYC_8, CYC_9);
               FM_SFR:   c = CYC_11;
               FM_PSW:   c = CYC_9;
               FM_HL:    c = pick(r.hs_ram, CYC_10, CYC_11);
               default:  c = CYC_8;
            endcase
         end
         OP_BIT_CLR: begin
            case (r.form)
               FM_SADDR, FM_HL: c = pick(r.hs_ram, CYC_10, CYC_11);
               FM_SFR, FM_PSW:  c = CYC_11;
               default:         c = CYC_8;
            endcase
         end
         OP_TEST_CLR: begin
            case (r.form)
               FM_SADDR, FM_HL: c = pick(r.hs_ram, CYC_10, CYC_12);
               FM_SFR, FM_PSW:  c = CYC_12;
               default:         c = CYC_8;
            endcase
         end
         OP_DEC_BR: begin
            c = (r.form == FM_SADDR) ? pick(r.hs_ram, CYC_8, CYC_10) : CYC_6;
         end
         OP_WORD_MOVE: begin
            c = CYC_WORD_MOVE;
         end
         default: begin
            c = CYC_6;
         end
      endcase
      if (!r.rom_fetch) begin
         c = c + EXT_FETCH_WAIT;
      end
      return c;
   endfunction

   function automatic btbc_res_s op_exec(input btbc_req_s r);
      btbc_res_s  o;
      logic       bitv;
      logic [7:0] dec;
      logic [15:0] disp;
      o = '0;
      bitv = r.operand[r.bit_sel];
      dec = r.operand - 8'h01;
      disp = {{8{r.offset[7]}}, r.offset};
      o.wr_form = r.form;
      case (r.op)
         OP_BIT_SET: begin
            o.taken = bitv;
         end
         OP_BIT_CLR: begin
            o.taken = !bitv;
         end
         OP_TEST_CLR: begin
            o.taken = bitv;
            o.wr_en = bitv;
            o.wr_data = r.operand & ~(8'h01 << r.bit_sel);
            o.flags_may_change = bitv && (r.form == FM_PSW);
         end
         OP_DEC_BR: begin
            o.wr_en = 1'b1;
            o.wr_data = dec;
            o.taken = (dec != 8'h00);
         end
         OP_WORD_MOVE: begin
            o.illegal = (r.rp_dst == RP_AX);
         end
         default: begin
            o.taken = 1'b0;
         end
      endcase
      o.next_pc = r.pc + {8'h00, op_len(r)} + (o.taken ? disp : 16'h0000);
      return o;
   endfunction

   assign res_nxt = op_exec(req);
   assign cyc_nxt = op_cycles(req);

   // cpu clock from the select register
   assign div_mask = (16'h0001 << clk_sel_r) - 16'h0001;
   // compare with >= so a smaller select never waits for the count to wrap
   assign cpu_tick = (pre_r >= div_mask);
   assign finish = (state_r == ST_EXEC) && cpu_tick && (cnt_r == 8'h01);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pre_r <= 16'h0000;
      end else if (ce) begin
         pre_r <= cpu_tick ? 16'h0000 : pre_r + 16'h0001;
      end
   end

   // select saturates so a bad write cannot stall the core
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clk_sel_r <= CTRL_SEL_RST;
      end else if (ce && reg_we && reg_addr == ADDR_CTRL) begin
         if (reg_wdata[CTRL_SEL_LSB +: 3] > CTRL_SEL_MAX) begin
            clk_sel_r <= CTRL_SEL_MAX;
         end else begin
            clk_sel_r <= reg_wdata[CTRL_SEL_LSB +: 3];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r    <= ST_IDLE;
         cnt_r      <= 8'h00;
         pend_r     <= '0;
         pend_op_r  <= OP_BIT_SET;
         busy       <= 1'b0;
         last_cyc_r <= 8'h00;
      end else if (ce) begin
         case (state_r)
            ST_IDLE: begin
               if (req_valid) begin
                  state_r    <= ST_EXEC;
                  cnt_r      <= cyc_nxt;
                  pend_r     <= res_nxt;
                  pend_op_r  <= req.op;
                  busy       <= 1'b1;
                  last_cyc_r <= cyc_nxt;
               end
            end
            ST_EXEC: begin
               if (cpu_tick) begin
                  cnt_r <= cnt_r - 8'h01;
               end
               if (finish) begin
                  if (pend_op_r == OP_HALT) begin
                     state_r <= ST_HALT;
                  end else if (pend_op_r == OP_STOP) begin
                     state_r <= ST_STOP;
                  end else begin
                     state_r <= ST_IDLE;
                     busy    <= 1'b0;
                  end
               end
            end
            ST_HALT, ST_STOP: begin
               if (standby_release) begin
                  state_r <= ST_IDLE;
                  busy    <= 1'b0;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               busy    <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         halted  <= 1'b0;
         stopped <= 1'b0;
      end else if (ce) begin
         // entry wins over release, matching the state machine
         if (finish) begin
            halted  <= (pend_op_r == OP_HALT);
            stopped <= (pend_op_r == OP_STOP);
         end else if (standby_release) begin
            halted  <= 1'b0;
            stopped <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         done      <= 1'b0;
         result    <= '0;
         illegal_r <= 1'b0;
      end else if (ce) begin
         done <= finish;
         if (finish) begin
            result    <= pend_r;
            illegal_r <= pend_r.illegal;
         end
      end
   end

   // flag changes land with the done pulse, not before
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ime <= IME_RST;
      end else if (ce && finish) begin
         if (pend_op_r == OP_UNMASK) begin
            ime <= 1'b1;
         end else if (pend_op_r == OP_MASK) begin
            ime <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (ce) begin
         reg_rdata <= 32'h0000_0000;
         if (reg_re) begin
            case (reg_addr)
               ADDR_CTRL: begin
                  reg_rdata[CTRL_SEL_LSB +: 3] <= clk_sel_r;
               end
               ADDR_STATUS: begin
                  reg_rdata[STAT_IME]     <= ime;
                  reg_rdata[STAT_HALTED]  <= halted;
                  reg_rdata[STAT_STOPPED] <= stopped;
                  reg_rdata[STAT_BUSY]    <= busy;
                  reg_rdata[STAT_ILLEGAL] <= illegal_r;
               end
               ADDR_CYCLES: begin
                  reg_rdata[7:0] <= last_cyc_r;
               end
               default: begin
                  reg_rdata <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// >>> btbc_pkg.sv
// btbc_pkg: types and constants for the compound branch and cpu control executor.
// assumes one clock domain; the sequencer supplies pre-fetched operands.
package btbc_pkg;

   typedef enum logic [3:0] {
      OP_BIT_SET,
      OP_BIT_CLR,
      OP_TEST_CLR,
      OP_DEC_BR,
      OP_UNMASK,
      OP_MASK,
      OP_HALT,
      OP_STOP,
      OP_WORD_MOVE
   } btbc_op_e;

   typedef enum logic [2:0] {
      FM_SADDR,
      FM_SFR,
      FM_ACC,
      FM_PSW,
      FM_HL,
      FM_REG_B,
      FM_REG_C
   } btbc_form_e;

   typedef struct packed {
      btbc_op_e   op;
      btbc_form_e form;
      logic [2:0] bit_sel;
      logic [7:0] operand;
      logic [7:0] offset;
      logic [15:0] pc;
      logic       hs_ram;
      logic       rom_fetch;
      logic [1:0] rp_dst;
   } btbc_req_s;

   typedef struct packed {
      logic [15:0] next_pc;
      logic        taken;
      logic        wr_en;
      logic [7:0]  wr_data;
      btbc_form_e  wr_form;
      logic        flags_may_change;
      logic        illegal;
   } btbc_res_s;

   typedef logic [7:0] btbc_cyc_t;

   // register map, byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CYCLES = 8'h08;

   // ctrl: cpu clock select, fcpu = ref_clk / 2^sel
   localparam int         CTRL_SEL_LSB  = 0;
   localparam logic [2:0] CTRL_SEL_RST  = 3'h0;
   localparam logic [2:0] CTRL_SEL_MAX  = 3'h4;

   // status bit positions
   localparam int STAT_IME     = 0;
   localparam int STAT_HALTED  = 1;
   localparam int STAT_STOPPED = 2;
   localparam int STAT_BUSY    = 3;
   localparam int STAT_ILLEGAL = 4;

   localparam logic       IME_RST = 1'b0;
   localparam logic [1:0] RP_AX   = 2'h0;

   // instruction lengths in bytes
   localparam logic [7:0] LEN_1 = 8'h01;
   localparam logic [7:0] LEN_2 = 8'h02;
   localparam logic [7:0] LEN_3 = 8'h03;
   localparam logic [7:0] LEN_4 = 8'h04;

   // cpu clock counts
   localparam btbc_cyc_t CYC_4  = 8'h04;
   localparam btbc_cyc_t CYC_6  = 8'h06;
   localparam btbc_cyc_t CYC_8  = 8'h08;
   localparam btbc_cyc_t CYC_9  = 8'h09;
   localparam btbc_cyc_t CYC_10 = 8'h0a;
   localparam btbc_cyc_t CYC_11 = 8'h0b;
   localparam btbc_cyc_t CYC_12 = 8'h0c;

   localparam int REF_CLK_PERIOD_NS = 10;

endpackage

// >>> btbc_dmem.sv
// btbc_dmem: one short direct data byte seen by the executor.
// assumes writebacks arrive with the done pulse of btbc_exec.
`timescale 1ns/1ps
`default_nettype none
module btbc_dmem
   import btbc_pkg::*;
#(
   parameter logic [7:0] INIT = 8'h03
) (
   input  wire logic      ref_clk,
   input  wire logic      rst,
   input  wire logic      done,
   input  wire btbc_res_s result,
   output logic [7:0]     mem_byte
);
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mem_byte <= INIT;
      end else if (done && result.wr_en && result.wr_form == FM_SADDR) begin
         mem_byte <= result.wr_data;
      end
   end
endmodule
`default_nettype wire

// >>> btbc_exec_asserts.sv
// btbc_exec_asserts: port-level checks of the executor.
// assumes binding to btbc_exec; op fields are latched at accept.
`timescale 1ns/1ps
`default_nettype none
module btbc_exec_asserts
   import btbc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        req_valid,
   input  wire btbc_req_s   req,
   input  wire logic        busy,
   input  wire logic        done,
   input  wire btbc_res_s   result,
   input  wire logic        ime,
   input  wire logic        reg_re,
   input  wire logic [31:0] reg_rdata
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   btbc_req_s q_r;
   logic      bit_v;
   // result belongs to the op accepted last, so keep it
   always_ff @(posedge ref_clk) begin
      if (ce && req_valid && !busy) begin
         q_r <= req;
      end
   end
   assign bit_v = q_r.operand[q_r.bit_sel];
   a_done_pulse: assert property (done && ce |=> !done)
      else $error("done longer than one cycle");
   a_accept_busy: assert property (ce && req_valid && !busy |=> busy)
      else $error("accepted op not busy");
   a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside read slot");
   a_result_hold: assert property (!done |-> $stable(result))
      else $error("result moved without done");
   a_unmask_ime: assert property (done && q_r.op == OP_UNMASK |-> ime)
      else $error("unmask left flag low");
   a_mask_ime: assert property (done && q_r.op == OP_MASK |-> !ime)
      else $error("mask left flag high");
   a_set_taken: assert property (
      done && q_r.op == OP_BIT_SET |-> result.taken == bit_v)
      else $error("set branch decision wrong");
   a_clr_taken: assert property (
      done && q_r.op == OP_BIT_CLR |-> result.taken == !bit_v)
      else $error("clear branch decision wrong");
   a_tclr_write: assert property (
      done && q_r.op == OP_TEST_CLR |-> result.taken == bit_v && result.wr_en == bit_v
      && result.flags_may_change == (bit_v && q_r.form == FM_PSW))
      else $error("test clear result wrong");
   a_dec_result: assert property (
      done && q_r.op == OP_DEC_BR |-> result.wr_en && result.wr_data == q_r.operand - 8'h01
      && result.taken == (q_r.operand != 8'h01))
      else $error("decrement result wrong");
   a_word_legal: assert property (
      done && q_r.op == OP_WORD_MOVE |-> result.illegal == (q_r.rp_dst == RP_AX))
      else $error("word move legality wrong");
   c_dec_taken: cover property (done && q_r.op == OP_DEC_BR && result.taken);
   c_tclr_psw: cover property (done && result.flags_may_change);
   c_illegal: cover property (done && result.illegal);
endmodule
`default_nettype wire

// >>> btbc_exec_test.sv
// btbc_exec_test: directed scenarios for the branch and cpu control executor.
// assumes btbc_pkg, btbc_dmem and btbc_exec_asserts compiled first.
`timescale 1ns/1ps
`default_nettype none
module btbc_exec_test
   import btbc_pkg::*;
;
   logic        ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, req_valid = 1'b0, standby_release = 1'b0;
   logic        reg_we = 1'b0, reg_re = 1'b0, busy, done, ime, halted, stopped;
   logic [7:0]  reg_addr = 8'h00, mem_byte;
   logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rv;
   btbc_req_s   req = '0, q;
   btbc_res_s   result;
   int          miscompares = 0, samples_checked = 0, n;
   always #5 ref_clk = ~ref_clk;
   // short fetch wait keeps the non-rom case cheap
   btbc_exec #(.EXT_FETCH_WAIT(8'h02)) btbc_exec_inst (.ref_clk(ref_clk), .rst(rst), .ce(ce),
      .req_valid(req_valid), .req(req), .standby_release(standby_release), .busy(busy),
      .done(done), .result(result), .ime(ime), .halted(halted), .stopped(stopped),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata));
   btbc_dmem btbc_dmem_inst (.ref_clk(ref_clk), .rst(rst), .done(done), .result(result),
      .mem_byte(mem_byte));
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic btbc_req_s mk(btbc_op_e op, btbc_form_e fm, logic [7:0] opd,
                                    logic [7:0] off, logic [15:0] pc, logic hs);
      return '{op, fm, 3'h7, opd, off, pc, hs, 1'b1, 2'h1};
   endfunction
   // n counts edges from accept to done
   task automatic wait_done(inout int cnt);
      do begin
         @(posedge ref_clk);
         #1;
         cnt++;
      end while (done !== 1'b1 && cnt < 200);
      if (cnt >= 200) begin
         miscompares++;
         close_out();
      end
   endtask
   task automatic run(output int cnt);
      req <= q;
      req_valid <= 1'b1;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      cnt = 0;
      wait_done(cnt);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge ref_clk);
      reg_we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge ref_clk);
      reg_re <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic s_regs;
      wr(ADDR_STATUS, 32'hffff_ffff);
      rd(ADDR_STATUS, rv);
      chk("status", 32'h0000_0000, rv);
      rd(8'h0c, rv);
      chk("unmapped", 32'h0000_0000, rv);
      wr(ADDR_CTRL, 32'h0000_0007);
      rd(ADDR_CTRL, rv);
      chk("ctrl", 32'h0000_0004, rv);
      q = mk(OP_DEC_BR, FM_REG_B, 8'h05, 8'h00, 16'h0000, 1'b1);
      run(n);
      chk("scaled", 1, n >= 81 && n <= 96);
      rd(ADDR_CYCLES, rv);
      chk("cycles_reg", 32'h0000_0006, rv);
      wr(ADDR_CTRL, 32'h0000_0000);
   endtask
   task automatic s_dec;
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         #1;
         chk("memory", 3 - i, mem_byte);
         q = mk(OP_DEC_BR, FM_SADDR, mem_byte, 8'h7f, 16'hfff0, 1'b0);
         q.rom_fetch = i != 0;
         run(n);
         chk("cycles", i == 0 ? 12 : 10, n);
         chk("next_pc", i < 2 ? 16'h0072 : 16'hfff3, result.next_pc);
      end
      for (int j = 0; j < 2; j++) begin
         q = mk(OP_DEC_BR, j ? FM_REG_C : FM_REG_B, j ? 8'h00 : 8'h01, 8'h10, 16'h0100, 1'b1);
         run(n);
         chk("cycles", 6, n);
         chk("dec", {j == 1, j ? 8'hff : 8'h00, j ? 16'h0112 : 16'h0102},
             {result.taken, result.wr_data, result.next_pc});
      end
   endtask
   task automatic s_bit_branch;
      int         cyc [3][5] = '{'{8, 11, 8, 9, 10}, '{10, 11, 8, 11, 10}, '{10, 12, 8, 12, 10}};
      logic [7:0] len;
      logic       tk;
      for (int o = 0; o < 3; o++) begin
         for (int f = 0; f < 5; f++) begin
            for (int v = 0; v < 2; v++) begin
               len = (f == 1 || (o > 0 && (f == 0 || f == 3))) ? LEN_4 : LEN_3;
               tk = (o == 1) ? (v == 0) : (v == 1);
               q = mk(btbc_op_e'(o), btbc_form_e'(f), v ? 8'h80 : 8'h7f, 8'h80, 16'h0010,
                      f != 1 && f != 3);
               run(n);
               chk("cycles", cyc[o][f], n);
               chk("next_pc", 16'h0010 + len + (tk ? 16'hff80 : 16'h0000), result.next_pc);
               chk("taken", tk, result.taken);
               if (o == 2) begin
                  chk("clear", {tk, tk && f == 3}, {result.wr_en, result.flags_may_change});
                  if (tk) begin
                     chk("wr_data", 8'h00, result.wr_data);
                  end
               end
            end
         end
      end
   endtask
   task automatic s_cpu;
      for (int k = 0; k < 4; k++) begin
         q = mk(btbc_op_e'(k + 4), FM_SADDR, 8'h00, 8'h00, 16'h0200, 1'b1);
         run(n);
         chk("cycles", 6, n);
         chk("next_pc", 16'h0202, result.next_pc);
         @(posedge ref_clk);
         #1;
         chk("state", {k == 0, k == 2, k == 3, k > 1}, {ime, halted, stopped, busy});
         if (k > 1) begin
            q.op = OP_UNMASK;
            req <= q;
            req_valid <= 1'b1;
            @(posedge ref_clk);
            req_valid <= 1'b0;
            standby_release <= 1'b1;
            @(posedge ref_clk);
            standby_release <= 1'b0;
            repeat (2) @(posedge ref_clk);
            #1;
            chk("released", 4'h0, {ime, halted, stopped, busy});
         end
      end
   endtask
   task automatic s_word;
      for (int r = 0; r < 4; r++) begin
         q = mk(OP_WORD_MOVE, FM_SADDR, 8'h00, 8'h00, 16'h0300, 1'b1);
         q.rp_dst = 2'(r);
         run(n);
         chk("illegal", r == 0, result.illegal);
         rd(ADDR_STATUS, rv);
         chk("status", r == 0, rv[STAT_ILLEGAL]);
      end
   endtask
   // ce low for ten edges must stretch the op by exactly ten
   task automatic s_freeze;
      q = mk(OP_DEC_BR, FM_REG_C, 8'h02, 8'h04, 16'h0040, 1'b1);
      req <= q;
      req_valid <= 1'b1;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      ce <= 1'b0;
      repeat (10) @(posedge ref_clk);
      ce <= 1'b1;
      n = 10;
      wait_done(n);
      chk("frozen", 16, n);
      chk("frozen_pc", 16'h0046, result.next_pc);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      s_regs();
      s_dec();
      s_bit_branch();
      s_cpu();
      s_word();
      s_freeze();
      close_out();
   end
endmodule
bind btbc_exec btbc_exec_asserts btbc_exec_asserts_inst (.ref_clk(ref_clk), .rst(rst), .ce(ce),
   .req_valid(req_valid), .req(req), .busy(busy), .done(done), .result(result), .ime(ime),
   .reg_re(reg_re), .reg_rdata(reg_rdata));
`default_nettype wire
